// ---- rtl/bdlnk_pkg.sv ----
// Shared constants and carrier types for the background debug port link.
package bdlnk_pkg;
   // Core clock period and the pulse and hold times of the reset lines
   localparam int CLK_PERIOD_NS = 10;
   localparam int SRST_PULSE_NS = 2000;
   localparam int HRST_PULSE_NS = 4000;
   localparam int CFG_HOLD_NS = 500;
   localparam int SRST_CYC = (SRST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HRST_CYC = (HRST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CFG_HOLD_CYC = (CFG_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 16;
   // Word layout of a serial transfer
   localparam int WORD_W = 32;
   localparam int FIFO_DEPTH = 4;
   localparam int BIT_CNT_W = 6;
   localparam int RX_FREEZE_BIT = 31;
   localparam logic [WORD_W-1:0] HRST_CMD_WORD = 32'h0000_0001;
   // Serial bit phases on the link clock: 0,1,3 clock low, 2 clock high
   localparam logic [1:0] PH_LAUNCH = 2'h0;
   localparam logic [1:0] PH_RISE = 2'h1;
   localparam logic [1:0] PH_SAMPLE = 2'h3;
   // Level of the data-out line that marks the target ready
   localparam logic READY_LEVEL = 1'b0;

   // Static configuration of the probe
   typedef struct packed {
      logic srst_out_only; // Target family whose soft reset line is an output only
      logic hrst_by_cmd; // Hard reset is sent as a protocol command
      logic status_unused; // Halt status pins are open or tied high
      logic cfg_clk; // Level held on the serial clock at soft reset release
      logic cfg_data; // Level held on the serial data-in at soft reset release
   } bdlnk_mode_t;

   // Drive pair of a two-way pin
   typedef struct packed {
      logic out;
      logic oe;
   } bdlnk_drv_t;
endpackage

// ---- rtl/bdlnk_fifo.sv ----
// Word FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module bdlnk_fifo #(
   parameter int W = 32,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic nrst_in,
   // Fill side
   input wire logic in_valid_in,
   input wire logic [W-1:0] in_data_in,
   output logic in_ready_out,
   // Drain side
   output logic out_valid_out,
   output logic [W-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin
         $error("bdlnk_fifo: DEPTH must be a power of two of at least 2");
      end
   end

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
      logic in_ready;
   } bdlnk_fifo_st_t;

   bdlnk_fifo_st_t st;
   bdlnk_fifo_st_t next_st;
   logic push;
   logic pop;

   // Pointer, count and registered ready update
   always_comb begin
      next_st = st;
      push = in_valid_in && st.in_ready;
      pop = out_ready_in && (st.cnt != '0);
      if (push) begin
         next_st.mem[st.wr] = in_data_in;
         next_st.wr = st.wr + 1'b1;
      end
      if (pop) begin
         next_st.rd = st.rd + 1'b1;
      end
      next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      next_st.in_ready = (next_st.cnt != (AW + 1)'(DEPTH));
      if (!nrst_in) begin
         next_st = '0;
         next_st.in_ready = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      st <= next_st;
   end

   assign in_ready_out = st.in_ready;
   assign out_valid_out = (st.cnt != '0);
   assign out_data_out = st.mem[st.rd];
endmodule

// ---- rtl/bdlnk_top.sv ----
// Probe side of the background debug port: serial link, reset lines and halt detection.
`timescale 1ns/100ps
// Contract
// (RL1) Target counts as halted only while both halt status inputs are high.
// (RL2) Configuration levels are held on serial clock and data-in across soft reset release.
// (RL3) For bidirectional soft reset, the probe may pull the line low to start one.
// (RL4) For the output-only soft reset family, the probe never drives that line.
// (RL5) Hard reset line low from either side puts the target into hard reset.
// (RL6) The probe generates the debug serial clock; the target clocks data by it.
// (RL7) All command and data bits go serially out on the data-in line.
// (RL8) Target shifts a data-out bit on the same clock as each data-in bit.
// (RL9) No transfer starts until the data-out line shows the target ready.
// (RL10) Serial clock and data-in also set target configuration during soft reset.
// (RL11) For the command-capable family, hard reset is sent as a protocol command.
// (RL12) Halt is still detected with status pins open or tied high, another way.
// (RL13) Data-out is sampled once per shifted bit, assembled in sending order.
module bdlnk_top (
   // Core clock and reset
   input wire logic core_clk_in,
   input wire logic nrst_in,
   // Link clock
   input wire logic link_clk_in,
   // Configuration and requests
   input wire bdlnk_pkg::bdlnk_mode_t mode_in,
   input wire logic soft_reset_req_in,
   input wire logic hard_reset_req_in,
   // Transmit words
   input wire logic tx_valid_in,
   input wire logic [bdlnk_pkg::WORD_W-1:0] tx_data_in,
   output logic tx_ready_out,
   // Received words
   output logic rx_valid_out,
   output logic [bdlnk_pkg::WORD_W-1:0] rx_data_out,
   // Status
   output logic halted_out,
   output logic busy_out,
   output logic hard_reset_seen_out,
   output logic soft_reset_seen_out,
   // Target pins
   input wire logic halt_status_a_in,
   input wire logic halt_status_b_in,
   input wire logic soft_reset_line_in,
   output bdlnk_pkg::bdlnk_drv_t soft_reset_line_out,
   input wire logic hard_reset_line_in,
   output bdlnk_pkg::bdlnk_drv_t hard_reset_line_out,
   output logic debug_serial_clock_out,
   output logic debug_serial_data_in_out,
   input wire logic debug_serial_data_out_in
);
   localparam int W = bdlnk_pkg::WORD_W;
   localparam int CW = bdlnk_pkg::CNT_W;

   typedef enum {C_IDLE, C_BUSY, C_SRST, C_SRST_REL, C_HRST} bdlnk_cst_t;
   typedef enum {L_IDLE, L_WAIT_RDY, L_SHIFT} bdlnk_lst_t;

   // Core domain state
   typedef struct packed {
      bdlnk_cst_t fsm;
      logic [1:0] sync_a;
      logic [1:0] sync_b;
      logic [1:0] sync_srst;
      logic [1:0] sync_hrst;
      logic [1:0] sync_ack;
      logic ack_last;
      logic req;
      logic [W-1:0] hold;
      logic [CW-1:0] cnt;
      logic srst_drive;
      logic hrst_drive;
      logic cfg_hold;
      logic cfg_clk;
      logic cfg_data;
      logic freeze_flag;
      logic halted;
      logic rx_valid;
      logic [W-1:0] rx_word;
      logic hrst_seen;
      logic srst_seen;
      logic busy;
   } bdlnk_core_t;

   // Link domain state
   typedef struct packed {
      bdlnk_lst_t fsm;
      logic [1:0] sync_req;
      logic req_last;
      logic [1:0] sync_debug_serial_data_out;
      logic [1:0] sync_hold;
      logic ack;
      logic [1:0] phase;
      logic [bdlnk_pkg::BIT_CNT_W-1:0] bits;
      logic [W-1:0] tx_sh;
      logic [W-1:0] rx_sh;
      logic [W-1:0] rx_word;
      logic debug_serial_clock;
      logic debug_serial_data_in;
   } bdlnk_link_t;

   bdlnk_core_t cs;
   bdlnk_core_t next_cs;
   bdlnk_link_t ls;
   bdlnk_link_t next_ls;
   logic [1:0] link_rst_sync;
   logic link_nrst;
   logic fifo_valid;
   logic [W-1:0] fifo_data;
   logic fifo_pop;
   logic srst_low;
   logic hrst_low;
   logic ack_edge;

   initial begin
      if (W >= (1 << bdlnk_pkg::BIT_CNT_W) || bdlnk_pkg::RX_FREEZE_BIT >= W) begin
         $error("bdlnk_top: word width does not fit the bit counter");
      end
      if (W < 2) begin
         $error("bdlnk_top: word width must be at least two bits");
      end
      if (bdlnk_pkg::SRST_CYC >= (1 << CW) || bdlnk_pkg::HRST_CYC >= (1 << CW)
         || bdlnk_pkg::CFG_HOLD_CYC >= (1 << CW)) begin
         $error("bdlnk_top: reset timing does not fit the cycle counter");
      end
   end

   // Transmit word buffer; back-pressure reaches the source through tx_ready_out
   bdlnk_fifo #(
      .W(W),
      .DEPTH(bdlnk_pkg::FIFO_DEPTH)
   ) u_fifo (
      .core_clk_in(core_clk_in),
      .nrst_in(nrst_in),
      .in_valid_in(tx_valid_in),
      .in_data_in(tx_data_in),
      .in_ready_out(tx_ready_out),
      .out_valid_out(fifo_valid),
      .out_data_out(fifo_data),
      .out_ready_in(fifo_pop)
   );

   // Synchronised pin levels and handshake edge seen by the core
   assign srst_low = ~cs.sync_srst[1];
   assign hrst_low = ~cs.sync_hrst[1];
   assign ack_edge = cs.sync_ack[1] != cs.ack_last;
   assign fifo_pop = (cs.fsm == C_IDLE) && fifo_valid && !cs.cfg_hold && !hrst_low
      && !soft_reset_req_in && !hard_reset_req_in;

   // Core sequencing: word hand-off, reset lines, configuration hold, halt detection
   always_comb begin
      next_cs = cs;
      next_cs.sync_a = {cs.sync_a[0], halt_status_a_in};
      next_cs.sync_b = {cs.sync_b[0], halt_status_b_in};
      next_cs.sync_srst = {cs.sync_srst[0], soft_reset_line_in};
      next_cs.sync_hrst = {cs.sync_hrst[0], hard_reset_line_in};
      next_cs.sync_ack = {cs.sync_ack[0], ls.ack};
      next_cs.rx_valid = 1'b0;
      next_cs.hrst_seen = hrst_low; // Target is in hard reset while the line is low [RL5]
      next_cs.srst_seen = srst_low;
      if (ack_edge) begin
         next_cs.ack_last = cs.sync_ack[1];
      end
      // A soft reset started by the target still needs configuration held [RL2]
      if (srst_low && cs.fsm != C_SRST && cs.fsm != C_SRST_REL) begin
         next_cs.cfg_hold = 1'b1;
         next_cs.cfg_clk = mode_in.cfg_clk;
         next_cs.cfg_data = mode_in.cfg_data;
      end
      case (cs.fsm)
         C_IDLE: begin
            if (cs.cfg_hold && !srst_low) begin
               next_cs.fsm = C_SRST_REL;
               next_cs.cnt = '0;
            end else if (soft_reset_req_in) begin
               next_cs.cfg_hold = 1'b1; // Configuration levels on clock and data-in [RL10]
               next_cs.cfg_clk = mode_in.cfg_clk;
               next_cs.cfg_data = mode_in.cfg_data;
               next_cs.srst_drive = !mode_in.srst_out_only; // [RL3] [RL4]
               next_cs.cnt = '0;
               next_cs.fsm = C_SRST;
            end else if (hard_reset_req_in && mode_in.hrst_by_cmd && !hrst_low) begin
               next_cs.hold = bdlnk_pkg::HRST_CMD_WORD; // Hard reset as a command [RL11]
               next_cs.req = ~cs.req;
               next_cs.busy = 1'b1;
               next_cs.fsm = C_BUSY;
            end else if (hard_reset_req_in && !mode_in.hrst_by_cmd) begin
               next_cs.hrst_drive = 1'b1; // Pull the hard reset line low [RL5]
               next_cs.cnt = '0;
               next_cs.fsm = C_HRST;
            end else if (fifo_pop) begin
               next_cs.hold = fifo_data;
               next_cs.req = ~cs.req;
               next_cs.busy = 1'b1;
               next_cs.fsm = C_BUSY;
            end
         end
         C_BUSY: begin
            if (ack_edge) begin
               next_cs.rx_word = ls.rx_word;
               next_cs.rx_valid = 1'b1;
               next_cs.freeze_flag = ls.rx_word[bdlnk_pkg::RX_FREEZE_BIT]; // [RL12]
               next_cs.busy = 1'b0;
               next_cs.fsm = C_IDLE;
            end
         end
         C_SRST: begin
            next_cs.cnt = cs.cnt + 1'b1;
            if (cs.cnt == CW'(bdlnk_pkg::SRST_CYC - 1)) begin
               next_cs.srst_drive = 1'b0;
               next_cs.cnt = '0;
               next_cs.fsm = C_SRST_REL;
            end
         end
         C_SRST_REL: begin
            // Wait for the line to rise, then keep the levels a while longer [RL2]
            if (srst_low) begin
               next_cs.cnt = '0;
            end else begin
               next_cs.cnt = cs.cnt + 1'b1;
               if (cs.cnt == CW'(bdlnk_pkg::CFG_HOLD_CYC - 1)) begin
                  next_cs.cfg_hold = 1'b0;
                  next_cs.fsm = C_IDLE;
               end
            end
         end
         C_HRST: begin
            next_cs.cnt = cs.cnt + 1'b1;
            if (cs.cnt == CW'(bdlnk_pkg::HRST_CYC - 1)) begin
               next_cs.hrst_drive = 1'b0;
               next_cs.fsm = C_IDLE;
            end
         end
         default: begin
            next_cs.fsm = C_IDLE;
         end
      endcase
      // Halt from the two status pins, or from the reply flag when they are unused
      if (mode_in.status_unused) begin
         next_cs.halted = next_cs.freeze_flag; // [RL12]
      end else begin
         next_cs.halted = cs.sync_a[1] && cs.sync_b[1]; // [RL1]
      end
      if (mode_in.srst_out_only) begin
         next_cs.srst_drive = 1'b0; // Output-only soft reset is never driven [RL4]
      end
      if (!nrst_in) begin
         next_cs = '0;
         next_cs.fsm = C_IDLE;
         next_cs.sync_srst = 2'h3;
         next_cs.sync_hrst = 2'h3;
      end
   end

   always_ff @(posedge core_clk_in) begin
      cs <= next_cs;
   end

   // Reset brought into the link domain
   always_ff @(posedge link_clk_in) begin
      link_rst_sync <= {link_rst_sync[0], nrst_in};
   end
   assign link_nrst = link_rst_sync[1];

   // Link engine: generates the serial clock and shifts words full duplex
   always_comb begin
      next_ls = ls;
      next_ls.sync_req = {ls.sync_req[0], cs.req};
      next_ls.sync_debug_serial_data_out = {ls.sync_debug_serial_data_out[0], debug_serial_data_out_in};
      next_ls.sync_hold = {ls.sync_hold[0], cs.cfg_hold};
      case (ls.fsm)
         L_IDLE: begin
            next_ls.debug_serial_clock = 1'b0;
            if (ls.sync_req[1] != ls.req_last) begin
               next_ls.req_last = ls.sync_req[1];
               next_ls.tx_sh = cs.hold; // Stable while the request toggle is pending
               next_ls.fsm = L_WAIT_RDY;
            end
         end
         L_WAIT_RDY: begin
            // Hold off until the data-out line reports ready [RL9]
            if (ls.sync_debug_serial_data_out[1] == bdlnk_pkg::READY_LEVEL && !ls.sync_hold[1]) begin
               next_ls.phase = bdlnk_pkg::PH_LAUNCH;
               next_ls.bits = '0;
               next_ls.fsm = L_SHIFT;
            end
         end
         L_SHIFT: begin
            next_ls.phase = ls.phase + 1'b1;
            if (ls.phase == bdlnk_pkg::PH_LAUNCH) begin
               // Previous bit has crossed both data-out flops by now [RL13] [RL8]
               if (ls.bits != '0) begin
                  next_ls.rx_sh = {ls.rx_sh[W-2:0], ls.sync_debug_serial_data_out[1]};
               end
               if (ls.bits == bdlnk_pkg::BIT_CNT_W'(W)) begin
                  // Last sample taken; hand the word over to the core
                  next_ls.rx_word = {ls.rx_sh[W-2:0], ls.sync_debug_serial_data_out[1]};
                  next_ls.ack = ~ls.ack;
                  next_ls.fsm = L_IDLE;
               end else begin
                  next_ls.debug_serial_data_in = ls.tx_sh[W-1]; // Bits leave MSB first on data-in [RL7]
                  next_ls.tx_sh = {ls.tx_sh[W-2:0], 1'b0};
               end
            end
            if (ls.phase == bdlnk_pkg::PH_RISE) begin
               next_ls.debug_serial_clock = 1'b1; // Probe-made serial clock [RL6]
            end
            if (ls.phase == bdlnk_pkg::PH_SAMPLE - 1'b1) begin
               next_ls.debug_serial_clock = 1'b0;
            end
            if (ls.phase == bdlnk_pkg::PH_SAMPLE) begin
               next_ls.bits = ls.bits + 1'b1; // Count the bit just clocked
            end
         end
         default: begin
            next_ls.fsm = L_IDLE;
         end
      endcase
      // Configuration levels override the idle lines during soft reset [RL10] [RL2]
      if (ls.sync_hold[1] && ls.fsm != L_SHIFT) begin
         next_ls.debug_serial_clock = cs.cfg_clk;
         next_ls.debug_serial_data_in = cs.cfg_data;
      end
      if (!link_nrst) begin
         next_ls = '0;
         next_ls.fsm = L_IDLE;
      end
   end

   always_ff @(posedge link_clk_in) begin
      ls <= next_ls;
   end

   // Outputs taken from flip-flops of either domain
   assign rx_valid_out = cs.rx_valid;
   assign rx_data_out = cs.rx_word;
   assign halted_out = cs.halted;
   assign busy_out = cs.busy;
   assign hard_reset_seen_out = cs.hrst_seen;
   assign soft_reset_seen_out = cs.srst_seen;
   assign soft_reset_line_out = '{out: 1'b0, oe: cs.srst_drive}; // [RL3]
   assign hard_reset_line_out = '{out: 1'b0, oe: cs.hrst_drive};
   assign debug_serial_clock_out = ls.debug_serial_clock;
   assign debug_serial_data_in_out = ls.debug_serial_data_in;
endmodule

// ---- verif/bdlnk_monitor.sv ----
// Concurrent checks on the probe's pins and status outputs.
`timescale 1ns/100ps
module bdlnk_monitor (
   // Clocks and reset
   input wire logic core_clk_in,
   input wire logic link_clk_in,
   input wire logic nrst_in,
   // Configuration and status
   input wire bdlnk_pkg::bdlnk_mode_t mode_in,
   input wire logic halt_status_a_in,
   input wire logic halt_status_b_in,
   input wire logic halted_out,
   input wire logic rx_valid_out,
   // Target pins
   input wire bdlnk_pkg::bdlnk_drv_t soft_reset_line_out,
   input wire bdlnk_pkg::bdlnk_drv_t hard_reset_line_out,
   input wire logic debug_serial_clock_out,
   input wire logic debug_serial_data_in_out
);
   // Halt status follows the pins once they settle
   halt_low_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (!mode_in.status_unused && !(halt_status_a_in && halt_status_b_in)) [*6]
      |-> !halted_out) else $error("halt without both pins");
   halt_both_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (!mode_in.status_unused && halt_status_a_in && halt_status_b_in) [*6]
      |-> halted_out) else $error("halt missed");
   // Reset line drive
   soft_quiet_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      mode_in.srst_out_only |-> !soft_reset_line_out.oe) else $error("soft line driven");
   soft_pulse_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      $rose(soft_reset_line_out.oe) |-> ##198 soft_reset_line_out.oe
      ##[1:3] !soft_reset_line_out.oe) else $error("soft pulse length");
   pull_low_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (soft_reset_line_out.oe || hard_reset_line_out.oe)
      |-> !(soft_reset_line_out.out || hard_reset_line_out.out)) else $error("drives high");
   hard_cmd_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      mode_in.hrst_by_cmd |-> !hard_reset_line_out.oe) else $error("hard line driven");
   hard_pulse_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      $rose(hard_reset_line_out.oe) |-> ##300 hard_reset_line_out.oe
      ##[98:101] !hard_reset_line_out.oe) else $error("hard pulse length");
   // Serial clock shape and data stability
   clk_pulse_a: assert property (@(posedge link_clk_in) disable iff (!nrst_in)
      (!mode_in.cfg_clk && $rose(debug_serial_clock_out))
      |-> ##[1:2] !debug_serial_clock_out) else $error("serial clock too long");
   data_hold_a: assert property (@(posedge link_clk_in) disable iff (!nrst_in)
      (!mode_in.cfg_clk && debug_serial_clock_out)
      |-> $stable(debug_serial_data_in_out)) else $error("data moved in high clock");
   rx_pulse_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      rx_valid_out |=> !rx_valid_out) else $error("receive pulse too long");
endmodule

// ---- verif/bdlnk_target.sv ----
// Target-side model of the debug port controller.
`timescale 1ns/100ps
module bdlnk_target (
   // Link pins
   input wire logic link_clk_in,
   input wire logic sclk_in,
   input wire logic sdi_in,
   input wire logic soft_line_in,
   input wire logic hard_line_in,
   output logic sdo_out,
   // Bench control and view
   input wire logic stall_in,
   input wire logic [31:0] reply_in,
   output logic [31:0] got_out,
   output logic [1:0] cfg_out
);
   logic [4:0] nbit = 5'h00;
   logic bit_q = 1'b0;
   logic [3:0] quiet = 4'h0;
   // Shift in and present the next reply bit on each rising clock
   always @(posedge sclk_in) begin
      got_out <= {got_out[30:0], sdi_in};
      bit_q <= reply_in[5'h1f - nbit];
      nbit <= nbit + 5'h01;
   end
   // Count quiet link cycles to find the end of a frame
   always @(posedge link_clk_in) begin
      if (sclk_in)
         quiet <= 4'h0;
      else if (quiet != 4'hf)
         quiet <= quiet + 4'h1;
   end
   // Low means ready; stalled or held in hard reset shows high
   assign sdo_out = (stall_in || !hard_line_in) ? 1'b1 :
      ((sclk_in || quiet < 4'h8) ? bit_q : 1'b0);
   // Configuration is taken as the soft reset line rises
   always @(posedge soft_line_in) cfg_out <= {sclk_in, sdi_in};
endmodule

// ---- verif/tb_background_debug_port_link.sv ----
// Self-checking bench for the background debug port link.
`timescale 1ns/100ps
module tb_background_debug_port_link;
   logic clk = 1'b0, lclk = 1'b0, nrst = 1'b0, sreq = 1'b0, hreq = 1'b0;
   logic ha = 1'b0, hb = 1'b0, tx_valid = 1'b0, stall = 1'b0;
   logic [31:0] tx_data = 32'h0000_0000, reply = 32'h0000_0000, rx_data, got;
   logic tx_ready, rx_valid, halted, busy, hseen, sseen, sclk, sdi, sdo;
   logic [1:0] cfg;
   bdlnk_pkg::bdlnk_mode_t mode = 5'h01;
   bdlnk_pkg::bdlnk_drv_t sdrv, hdrv;
   int n_errors = 0, samples_checked = 0;
   // Open-drain lines with pull-ups
   wire soft_line = !sdrv.oe;
   wire hard_line = !hdrv.oe;
   always #5 clk = ~clk;
   // Link clock, offset in phase
   initial begin
      #17;
      forever #62.5 lclk = ~lclk;
   end
   bdlnk_top dut_u (.core_clk_in(clk), .nrst_in(nrst), .link_clk_in(lclk), .mode_in(mode),
      .soft_reset_req_in(sreq), .hard_reset_req_in(hreq), .tx_valid_in(tx_valid),
      .tx_data_in(tx_data), .tx_ready_out(tx_ready), .rx_valid_out(rx_valid),
      .rx_data_out(rx_data), .halted_out(halted), .busy_out(busy),
      .hard_reset_seen_out(hseen), .soft_reset_seen_out(sseen), .halt_status_a_in(ha),
      .halt_status_b_in(hb), .soft_reset_line_in(soft_line), .soft_reset_line_out(sdrv),
      .hard_reset_line_in(hard_line), .hard_reset_line_out(hdrv),
      .debug_serial_clock_out(sclk), .debug_serial_data_in_out(sdi),
      .debug_serial_data_out_in(sdo));
   bdlnk_target tgt_u (.link_clk_in(lclk), .sclk_in(sclk), .sdi_in(sdi),
      .soft_line_in(soft_line), .hard_line_in(hard_line), .sdo_out(sdo), .stall_in(stall),
      .reply_in(reply), .got_out(got), .cfg_out(cfg));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic do_reset(input bdlnk_pkg::bdlnk_mode_t m);
      nrst <= 1'b0;
      mode <= m;
      repeat (12) @(posedge lclk);
      @(posedge clk);
      nrst <= 1'b1;
      repeat (40) @(posedge clk);
   endtask
   task automatic send(input int n, input logic [31:0] base);
      for (int i = 0; i < n; i++) begin
         tx_valid <= 1'b1;
         tx_data <= base + i;
         @(posedge clk);
         while (!tx_ready) @(posedge clk);
      end
      tx_valid <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_rx(output logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      while (rx_valid !== 1'b1 && k < 4000) begin
         @(posedge clk);
         k++;
      end
      chk(rx_valid, 1'b1);
      d = rx_data;
   endtask
   // Width of one drive pulse on a reset line
   task automatic count_oe(input bit hard, output int n);
      n = 0;
      @(posedge clk);
      while (!(hard ? hdrv.oe : sdrv.oe) && n < 20) @(posedge clk);
      while ((hard ? hdrv.oe : sdrv.oe) && n < 1000) begin
         @(posedge clk);
         n++;
      end
      chk(hard ? hseen : sseen, 1'b1);
   endtask
   task automatic t_halt;
      for (int i = 0; i < 4; i++) begin
         ha <= i[0];
         hb <= i[1];
         repeat (8) @(posedge clk);
         chk(halted, i == 3);
      end
      ha <= 1'b0;
      hb <= 1'b0;
      $display("halt pins done");
   endtask
   task automatic t_xfer;
      logic [31:0] d;
      reply <= 32'hA5C3_0F96;
      send(2, 32'h8001_2346);
      chk(busy, 1'b1);
      for (int i = 0; i < 2; i++) begin
         wait_rx(d);
         chk(d, 32'hA5C3_0F96);
         chk(got, 32'h8001_2346 + i);
      end
      chk(busy, 1'b0);
      $display("transfer done");
   endtask
   // Target holds off; FIFO fills and refuses, then drains in order
   task automatic t_fill;
      logic [31:0] d;
      int n;
      n = 0;
      stall <= 1'b1;
      tx_valid <= 1'b1;
      tx_data <= 32'h0000_1000;
      repeat (300) begin
         @(posedge clk);
         if (tx_ready) begin
            n++;
            tx_data <= 32'h0000_1000 + n;
         end
         chk(rx_valid, 1'b0);
      end
      tx_valid <= 1'b0;
      chk(n, bdlnk_pkg::FIFO_DEPTH + 1);
      stall <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         wait_rx(d);
         chk(got, 32'h0000_1000 + i);
      end
      $display("fill and drain done");
   endtask
   task automatic t_resets;
      int n;
      sreq <= 1'b1;
      @(posedge clk);
      sreq <= 1'b0;
      count_oe(1'b0, n);
      chk(n, bdlnk_pkg::SRST_CYC);
      repeat (100) @(posedge clk);
      chk(cfg, 2'h1);
      hreq <= 1'b1;
      @(posedge clk);
      hreq <= 1'b0;
      count_oe(1'b1, n);
      chk(n, bdlnk_pkg::HRST_CYC);
      $display("reset pulses done");
   endtask
   task automatic t_out_only;
      do_reset(5'h11);
      sreq <= 1'b1;
      repeat (30) @(posedge clk);
      sreq <= 1'b0;
      chk(sdrv.oe, 1'b0);
      $display("output-only soft line done");
   endtask
   // Hard reset by command, halt from the freeze bit with pins tied high
   task automatic t_cmd;
      logic [31:0] d;
      do_reset(5'h0D);
      reply <= 32'h0000_0000;
      ha <= 1'b1;
      hb <= 1'b1;
      hreq <= 1'b1;
      @(posedge clk);
      hreq <= 1'b0;
      wait_rx(d);
      chk(got, bdlnk_pkg::HRST_CMD_WORD);
      repeat (8) @(posedge clk);
      chk(halted, 1'b0);
      reply <= 32'h8000_0000;
      send(1, 32'h0000_0042);
      wait_rx(d);
      repeat (8) @(posedge clk);
      chk(halted, 1'b1);
      $display("command reset and freeze done");
   endtask
   initial begin
      do_reset(5'h01);
      t_halt;
      t_xfer;
      t_fill;
      t_resets;
      t_out_only;
      t_cmd;
      close_out;
   end
   // Watchdog against a hang
   initial begin
      repeat (40000) @(posedge clk);
      n_errors++;
      close_out;
   end
endmodule
bind bdlnk_top bdlnk_monitor mon_u (.core_clk_in, .link_clk_in, .nrst_in, .mode_in,
   .halt_status_a_in, .halt_status_b_in, .halted_out, .rx_valid_out, .soft_reset_line_out,
   .hard_reset_line_out, .debug_serial_clock_out, .debug_serial_data_in_out);
